// ===== rtl/mcuie_pkg.sv
// shared constants, opcodes and flag carrier for the instruction execute core
`default_nettype none
package mcuie_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DW          = 8;   // accumulator and register width
  localparam int IW          = 16;  // instruction word width
  localparam int PCW         = 11;  // program counter width
  localparam int EAW         = 8;   // effective register address width
  localparam int PCHW        = 3;   // high latch width
  localparam int REG_COUNT   = 144; // locations 0x00 to 0x8f
  localparam int STACK_DEPTH = 4;   // return address entries

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  localparam int OP_HI   = 15;
  localparam int OP_LO   = 11;
  localparam int DEST    = 10; // 1 = register, 0 = accumulator
  localparam int BIT_HI  = 9;
  localparam int BIT_LO  = 7;
  localparam int RADR_HI = 6;
  localparam int BANK_HI = 3;  // low address bits used in the high bank

  // ---------------------------------------------------------------
  // special register addresses and layout
  // ---------------------------------------------------------------
  localparam logic [7:0] PC_LOW_ADDR = 8'h02;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] PCHB_ADDR   = 8'h0a;
  localparam logic [3:0] HI_BANK_TOP = 4'h8;
  localparam int ST_C    = 0;
  localparam int ST_H    = 1;
  localparam int ST_Z    = 2;
  localparam int ST_BANK = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] PC_RESET  = 11'h000;
  localparam logic [7:0]  ACC_RESET = 8'h00;

  // ---------------------------------------------------------------
  // opcodes, encoded in declaration order
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    NOP_OP, add_reg_acc_op, add_imm_op, plus_one_op,
    plus_one_skip_zero_op, minus_acc_op, imm_minus_acc_op,
    minus_one_op, minus_one_skip_zero_op, CLEAR_OP,
    and_reg_acc_op, and_imm_op, invert_op, or_reg_acc_op,
    or_imm_op, xor_reg_acc_op, xor_imm_op, bit_clear_op,
    bit_set_op, test_skip_clear_op, test_skip_set_op,
    MOVE_TO_REG_OP, MOVE_TO_ACC_OP, load_imm_op,
    nibble_exchange_op, rotate_left_op, rotate_right_op,
    CALL_OP, JUMP_OP, return_with_imm_op,
    interrupt_return_op, RETURN_OP
  } mcuie_op_e;

  // status flags as one carrier
  typedef struct packed {
    logic bank_select;
    logic zero_flag;
    logic nibble_spill_flag;
    logic msb_spill_flag;
  } mcuie_flags_s;
endpackage
`default_nettype wire

// ===== rtl/mcuie_core.sv
// instruction decode and execute core with fetch, register file and stack
`default_nettype none
module mcuie_core #(
  parameter int STACK_DEPTH = mcuie_pkg::STACK_DEPTH  // return entries
) (
  input  wire  logic                          REF_CLK,    // core clock
  input  wire  logic                          NRST,       // async reset, low
  output logic [mcuie_pkg::PCW-1:0]           PM_ADDR,    // fetch address
  input  wire  logic [mcuie_pkg::IW-1:0]      PM_DATA,    // word, next cycle
  input  wire  logic                          INT_ACK,    // servicing taken
  output logic [mcuie_pkg::DW-1:0]            ACC,        // accumulator
  output mcuie_pkg::mcuie_flags_s             FLAGS,      // status flags
  output logic                                INT_EN,     // servicing on
  output logic                                EXEC_VALID  // word executed
);
  localparam int SPW = $clog2(STACK_DEPTH);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [mcuie_pkg::PCW-1:0]  pc_reg, pc_next;
  logic                       vld_reg, vld_next;
  logic [mcuie_pkg::DW-1:0]   acc_reg, acc_next;
  mcuie_pkg::mcuie_flags_s    flg_reg, flg_next;
  logic [mcuie_pkg::PCHW-1:0] pch_reg, pch_next;
  logic [SPW-1:0]             sp_reg, sp_next;
  logic                       ie_reg, ie_next;
  logic                       ex_reg, ex_next;

  logic [mcuie_pkg::DW-1:0]   regs [mcuie_pkg::REG_COUNT];
  logic [mcuie_pkg::PCW-1:0]  stack [STACK_DEPTH];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  mcuie_pkg::mcuie_op_e       op;
  logic [mcuie_pkg::DW-1:0]   imm;
  logic [2:0]                 bidx;
  logic [mcuie_pkg::DW-1:0]   bmask;
  logic [mcuie_pkg::EAW-1:0]  ea;
  logic [mcuie_pkg::DW-1:0]   opnd;
  logic                       dst_reg;

  assign op      = mcuie_pkg::mcuie_op_e'(PM_DATA[mcuie_pkg::OP_HI:mcuie_pkg::OP_LO]);
  assign imm     = PM_DATA[mcuie_pkg::DW-1:0];
  assign bidx    = PM_DATA[mcuie_pkg::BIT_HI:mcuie_pkg::BIT_LO];
  assign bmask   = 8'h01 << bidx;
  assign dst_reg = PM_DATA[mcuie_pkg::DEST];

  // bank address mapping; status, low pc and latch answer in both banks
  always_comb begin
    ea = {1'b0, PM_DATA[mcuie_pkg::RADR_HI:0]};
    if (flg_reg.bank_select && !(ea inside {mcuie_pkg::PC_LOW_ADDR, mcuie_pkg::STATUS_ADDR,
                                          mcuie_pkg::PCHB_ADDR})) begin
      ea = {mcuie_pkg::HI_BANK_TOP, PM_DATA[mcuie_pkg::BANK_HI:0]};
    end
  end

  always_comb begin
    case (ea)
      mcuie_pkg::STATUS_ADDR: begin
        opnd = 8'h00;
        opnd[mcuie_pkg::ST_BANK] = flg_reg.bank_select;
        opnd[mcuie_pkg::ST_Z]  = flg_reg.zero_flag;
        opnd[mcuie_pkg::ST_H]  = flg_reg.nibble_spill_flag;
        opnd[mcuie_pkg::ST_C]  = flg_reg.msb_spill_flag;
      end
      mcuie_pkg::PC_LOW_ADDR: opnd = pc_reg[mcuie_pkg::DW-1:0];
      mcuie_pkg::PCHB_ADDR: opnd = {5'h00, pch_reg};
      default: begin
        if (ea < 8'(mcuie_pkg::REG_COUNT)) begin
          opnd = regs[ea];
        end else begin
          opnd = 8'h00;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // execute: result, flag enables and flow controls per opcode
  // ---------------------------------------------------------------
  logic [8:0]               sum;
  logic [4:0]               nib;
  logic [mcuie_pkg::DW-1:0] res;
  logic                     to_reg, to_acc, set_z, set_ch, set_c;
  logic                     new_c, skip, branch, push, pop;
  logic [mcuie_pkg::PCW-1:0] target;
  logic                     wr_en;
  logic                     jump_now;
  logic [mcuie_pkg::PCW-1:0] jump_to;

  always_comb begin
    sum    = 9'h000;
    nib    = 5'h00;
    res    = 8'h00;
    to_reg = 1'b0;
    to_acc = 1'b0;
    set_z  = 1'b0;
    set_ch = 1'b0;
    set_c  = 1'b0;
    new_c  = flg_reg.msb_spill_flag;
    skip   = 1'b0;
    branch = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    target = PM_DATA[mcuie_pkg::PCW-1:0];
    case (op)
      mcuie_pkg::add_reg_acc_op, mcuie_pkg::add_imm_op: begin
        if (op == mcuie_pkg::add_imm_op) begin
          sum = {1'b0, imm} + {1'b0, acc_reg};
          nib = {1'b0, imm[3:0]} + {1'b0, acc_reg[3:0]};
        end else begin
          sum = {1'b0, opnd} + {1'b0, acc_reg};
          nib = {1'b0, opnd[3:0]} + {1'b0, acc_reg[3:0]};
        end
        res    = sum[7:0];
        new_c  = sum[8];
        to_reg = dst_reg && (op == mcuie_pkg::add_reg_acc_op);
        to_acc = !to_reg;
        set_ch = 1'b1;
      end
      // subtract as add of inverted acc, carry means no borrow
      mcuie_pkg::minus_acc_op, mcuie_pkg::imm_minus_acc_op: begin
        if (op == mcuie_pkg::imm_minus_acc_op) begin
          sum = {1'b0, imm} + {1'b0, ~acc_reg} + 9'h001;
          nib = {1'b0, imm[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
        end else begin
          sum = {1'b0, opnd} + {1'b0, ~acc_reg} + 9'h001;
          nib = {1'b0, opnd[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
        end
        res    = sum[7:0];
        new_c  = sum[8];
        to_reg = dst_reg && (op == mcuie_pkg::minus_acc_op);
        to_acc = !to_reg;
        set_ch = 1'b1;
      end
      mcuie_pkg::plus_one_op: begin
        res    = opnd + 8'h01;
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_z  = 1'b1;
      end
      mcuie_pkg::minus_one_op: begin
        res    = opnd - 8'h01;
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_z  = 1'b1;
      end
      mcuie_pkg::plus_one_skip_zero_op, mcuie_pkg::minus_one_skip_zero_op: begin
        if (op == mcuie_pkg::plus_one_skip_zero_op) begin
          res = opnd + 8'h01;
        end else begin
          res = opnd - 8'h01;
        end
        to_reg = dst_reg;
        to_acc = !dst_reg;
        skip   = (res == 8'h00);
      end
      mcuie_pkg::CLEAR_OP: begin
        res    = 8'h00;
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_z  = 1'b1;
      end
      mcuie_pkg::and_reg_acc_op, mcuie_pkg::or_reg_acc_op, mcuie_pkg::xor_reg_acc_op: begin
        if (op == mcuie_pkg::and_reg_acc_op) begin
          res = opnd & acc_reg;
        end else if (op == mcuie_pkg::or_reg_acc_op) begin
          res = opnd | acc_reg;
        end else begin
          res = opnd ^ acc_reg;
        end
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_z  = 1'b1;
      end
      mcuie_pkg::and_imm_op, mcuie_pkg::or_imm_op, mcuie_pkg::xor_imm_op: begin
        if (op == mcuie_pkg::and_imm_op) begin
          res = imm & acc_reg;
        end else if (op == mcuie_pkg::or_imm_op) begin
          res = imm | acc_reg;
        end else begin
          res = imm ^ acc_reg;
        end
        to_acc = 1'b1;
        set_z  = 1'b1;
      end
      mcuie_pkg::invert_op: begin
        res    = opnd ^ 8'hff;
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_z  = 1'b1;
      end
      mcuie_pkg::bit_clear_op, mcuie_pkg::bit_set_op: begin
        res    = (op == mcuie_pkg::bit_set_op) ? (opnd | bmask) : (opnd & ~bmask);
        to_reg = 1'b1;
      end
      mcuie_pkg::test_skip_clear_op: skip = ((opnd & bmask) == 8'h00);
      mcuie_pkg::test_skip_set_op:   skip = ((opnd & bmask) != 8'h00);
      mcuie_pkg::MOVE_TO_REG_OP: begin
        res    = acc_reg;
        to_reg = 1'b1;
      end
      mcuie_pkg::MOVE_TO_ACC_OP: begin
        res    = opnd;
        to_acc = 1'b1;
        set_z  = 1'b1;
      end
      mcuie_pkg::load_imm_op: begin
        res    = imm;
        to_acc = 1'b1;
      end
      mcuie_pkg::nibble_exchange_op: begin
        res    = {opnd[3:0], opnd[7:4]};
        to_reg = dst_reg;
        to_acc = !dst_reg;
      end
      mcuie_pkg::rotate_left_op, mcuie_pkg::rotate_right_op: begin
        if (op == mcuie_pkg::rotate_left_op) begin
          res   = {opnd[6:0], flg_reg.msb_spill_flag};
          new_c = opnd[7];
        end else begin
          res   = {flg_reg.msb_spill_flag, opnd[7:1]};
          new_c = opnd[0];
        end
        to_reg = dst_reg;
        to_acc = !dst_reg;
        set_c  = 1'b1;
      end
      // control transfer, refill costs a second cycle
      mcuie_pkg::CALL_OP, mcuie_pkg::JUMP_OP: begin
        branch = 1'b1;
        push   = (op == mcuie_pkg::CALL_OP);
      end
      mcuie_pkg::return_with_imm_op, mcuie_pkg::interrupt_return_op, mcuie_pkg::RETURN_OP: begin
        branch = 1'b1;
        pop    = 1'b1;
        target = stack[sp_reg - SPW'(1)];
        res    = imm;
        to_acc = (op == mcuie_pkg::return_with_imm_op);
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // write back, flags and program flow
  // ---------------------------------------------------------------
  always_comb begin
    pc_next  = pc_reg + 11'h001;
    vld_next = 1'b1;
    acc_next = acc_reg;
    flg_next = flg_reg;
    pch_next = pch_reg;
    sp_next  = sp_reg;
    ie_next  = ie_reg & ~INT_ACK;
    ex_next  = vld_reg;
    wr_en    = 1'b0;
    jump_now = branch;
    jump_to  = target;
    // idle slot: nothing changes from a dropped word
    if (vld_reg) begin
      if (to_acc) begin
        acc_next = res;
      end
      if (to_reg) begin
        case (ea)
          mcuie_pkg::STATUS_ADDR: begin
            flg_next.bank_select       = res[mcuie_pkg::ST_BANK];
            flg_next.zero_flag         = res[mcuie_pkg::ST_Z];
            flg_next.nibble_spill_flag = res[mcuie_pkg::ST_H];
            flg_next.msb_spill_flag    = res[mcuie_pkg::ST_C];
          end
          // computed branch from latch and low byte
          mcuie_pkg::PC_LOW_ADDR: begin
            jump_now = 1'b1;
            jump_to  = {pch_reg, res};
          end
          mcuie_pkg::PCHB_ADDR: pch_next = res[mcuie_pkg::PCHW-1:0];
          default: wr_en = (ea < 8'(mcuie_pkg::REG_COUNT));
        endcase
      end
      // flag updates win over an explicit status write
      if (set_ch) begin
        flg_next.msb_spill_flag    = new_c;
        flg_next.nibble_spill_flag = nib[4];
      end
      if (set_c) begin
        flg_next.msb_spill_flag = new_c;
      end
      if (set_z || set_ch) begin
        flg_next.zero_flag = (res == 8'h00);
      end
      // taken skip drops the word already fetched
      if (skip) begin
        vld_next = 1'b0;
      end
      if (jump_now) begin
        pc_next  = jump_to;
        vld_next = 1'b0;
      end
      if (push) begin
        sp_next = sp_reg + SPW'(1);
      end
      if (pop) begin
        sp_next = sp_reg - SPW'(1);
      end
      if (op == mcuie_pkg::interrupt_return_op) begin
        ie_next = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pc_reg  <= mcuie_pkg::PC_RESET;
      vld_reg <= 1'b0;
      acc_reg <= mcuie_pkg::ACC_RESET;
      flg_reg <= '0;
      pch_reg <= '0;
      sp_reg  <= '0;
      ie_reg  <= 1'b0;
      ex_reg  <= 1'b0;
    end else begin
      pc_reg  <= pc_next;
      vld_reg <= vld_next;
      acc_reg <= acc_next;
      flg_reg <= flg_next;
      pch_reg <= pch_next;
      sp_reg  <= sp_next;
      ie_reg  <= ie_next;
      ex_reg  <= ex_next;
    end
  end

  // data registers and return stack hold data only, no reset
  always_ff @(posedge REF_CLK) begin
    if (wr_en) begin
      regs[ea] <= res;
    end
    if (vld_reg && push) begin
      stack[sp_reg] <= pc_reg;
    end
  end

  // outputs straight from flip-flops
  assign PM_ADDR    = pc_reg;
  assign ACC        = acc_reg;
  assign FLAGS      = flg_reg;
  assign INT_EN     = ie_reg;
  assign EXEC_VALID = ex_reg;
endmodule // mcuie_core
`default_nettype wire

// ===== bench/mcuie_core_asserts.sv
// port checker for the instruction execute core
`default_nettype none
module mcuie_core_asserts #(
  parameter int STACK_DEPTH = mcuie_pkg::STACK_DEPTH  // return entries
) (
  input wire logic                      REF_CLK,    // core clock
  input wire logic                      NRST,       // async reset, low
  input wire logic [mcuie_pkg::PCW-1:0] PM_ADDR,    // fetch address
  input wire logic [mcuie_pkg::IW-1:0]  PM_DATA,    // fetched word
  input wire logic                      INT_ACK,    // servicing taken
  input wire logic [mcuie_pkg::DW-1:0]  ACC,        // accumulator
  input wire mcuie_pkg::mcuie_flags_s   FLAGS,      // status flags
  input wire logic                      INT_EN,     // servicing on
  input wire logic                      EXEC_VALID  // word executed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // the word just executed carried this opcode
  sequence s_ran(logic [4:0] code);
    EXEC_VALID && $past(PM_DATA[15:11]) == code;
  endsequence
  // the following fetched word was dropped
  sequence s_dropped;
    !EXEC_VALID;
  endsequence
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_nop_keeps;
    s_ran(mcuie_pkg::NOP_OP) |-> ACC == $past(ACC) && FLAGS == $past(FLAGS);
  endproperty
  property p_add_imm;
    s_ran(mcuie_pkg::add_imm_op)
      |-> {FLAGS.msb_spill_flag, ACC} == 9'($past(ACC)) + 9'($past(PM_DATA[7:0]))
      && FLAGS.nibble_spill_flag == (5'($past(ACC[3:0])) + 5'($past(PM_DATA[3:0])) > 5'h0f)
      && FLAGS.zero_flag == (ACC == 8'h00);
  endproperty
  property p_imm_minus_acc;
    s_ran(mcuie_pkg::imm_minus_acc_op) |-> ACC == $past(PM_DATA[7:0]) - $past(ACC)
      && FLAGS.msb_spill_flag == ($past(PM_DATA[7:0]) >= $past(ACC))
      && FLAGS.nibble_spill_flag == ($past(PM_DATA[3:0]) >= $past(ACC[3:0]));
  endproperty
  property p_load_imm;
    s_ran(mcuie_pkg::load_imm_op) |-> ACC == $past(PM_DATA[7:0]) && FLAGS == $past(FLAGS);
  endproperty
  property p_zero_only;
    EXEC_VALID && !$past(PM_DATA[10]) && $past(PM_DATA[15:11]) inside
      {mcuie_pkg::plus_one_op, mcuie_pkg::minus_one_op, mcuie_pkg::and_reg_acc_op,
       mcuie_pkg::or_reg_acc_op, mcuie_pkg::xor_reg_acc_op, mcuie_pkg::invert_op}
      |-> FLAGS.zero_flag == (ACC == 8'h00) && FLAGS.msb_spill_flag == $past(FLAGS.msb_spill_flag)
      && FLAGS.nibble_spill_flag == $past(FLAGS.nibble_spill_flag);
  endproperty
  property p_skip_acc;
    EXEC_VALID && !$past(PM_DATA[10]) && $past(PM_DATA[15:11]) inside
      {mcuie_pkg::plus_one_skip_zero_op, mcuie_pkg::minus_one_skip_zero_op}
      |-> FLAGS == $past(FLAGS) ##1 (EXEC_VALID == ($past(ACC) != 8'h00));
  endproperty
  property p_rotate_left;
    s_ran(mcuie_pkg::rotate_left_op) ##0 !$past(PM_DATA[10])
      |-> ACC[0] == $past(FLAGS.msb_spill_flag) && FLAGS.zero_flag == $past(FLAGS.zero_flag);
  endproperty
  property p_ret_imm;
    s_ran(mcuie_pkg::return_with_imm_op) |-> ACC == $past(PM_DATA[7:0]) ##1 s_dropped;
  endproperty
  property p_jump;
    s_ran(mcuie_pkg::JUMP_OP) |-> PM_ADDR == $past(PM_DATA[10:0]) ##1 s_dropped;
  endproperty
  property p_int_return;
    s_ran(mcuie_pkg::interrupt_return_op) |-> INT_EN ##1 s_dropped;
  endproperty
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_nop_keeps: assert property (p_nop_keeps) else $error("nop changed state");
  a_add_imm: assert property (p_add_imm) else $error("add imm wrong");
  a_imm_minus_acc: assert property (p_imm_minus_acc) else $error("sub imm wrong");
  a_load_imm: assert property (p_load_imm) else $error("load imm wrong");
  a_zero_only: assert property (p_zero_only) else $error("flags beyond zero");
  a_skip_acc: assert property (p_skip_acc) else $error("skip wrong");
  a_rotate_left: assert property (p_rotate_left) else $error("rotate wrong");
  a_ret_imm: assert property (p_ret_imm) else $error("return imm wrong");
  a_jump: assert property (p_jump) else $error("jump wrong");
  a_int_return: assert property (p_int_return) else $error("int return wrong");
endmodule // mcuie_core_asserts

bind mcuie_core mcuie_core_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_mcuie_core_asserts (
  .REF_CLK(REF_CLK), .NRST(NRST), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .INT_ACK(INT_ACK),
  .ACC(ACC), .FLAGS(FLAGS), .INT_EN(INT_EN), .EXEC_VALID(EXEC_VALID));
`default_nettype wire

// ===== bench/mcuie_prog_rom.sv
// program memory model feeding the core one word per cycle
`default_nettype none
module mcuie_prog_rom (
  input  wire logic [0:0]                clk,   // core clock
  input  wire logic [mcuie_pkg::PCW-1:0] addr,  // fetch address
  output var  logic [mcuie_pkg::IW-1:0]  data   // word, one cycle later
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [mcuie_pkg::IW-1:0]  mem [0:(1<<mcuie_pkg::PCW)-1];
  logic [mcuie_pkg::PCW-1:0] addr_reg = '0;
  // hold the address left behind at each rising edge
  always @(posedge clk) addr_reg <= addr;
  // present its word at the following falling edge
  always @(negedge clk) data <= mem[addr_reg];
  initial data = '0;
endmodule // mcuie_prog_rom
`default_nettype wire

// ===== bench/mcuie_core_tb_top.sv
// self-checking bench for the instruction execute core
`default_nettype none
module mcuie_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     ref_clk = 1'b0;
  logic                     nrst    = 1'b0;
  logic                     int_ack = 1'b0;
  logic [10:0]              pm_addr, at;
  logic [15:0]              pm_data;
  logic [7:0]               acc;
  mcuie_pkg::mcuie_flags_s  flags;
  logic                     int_en, exec_valid;
  int                       fails = 0;
  int                       checked = 0;
  // clock toggles every half period
  always #5 ref_clk = ~ref_clk;
  mcuie_core u_mcuie_core (.REF_CLK(ref_clk), .NRST(nrst), .PM_ADDR(pm_addr),
    .PM_DATA(pm_data), .INT_ACK(int_ack), .ACC(acc), .FLAGS(flags), .INT_EN(int_en),
    .EXEC_VALID(exec_valid));
  mcuie_prog_rom u_mcuie_prog_rom (.clk(ref_clk), .addr(pm_addr), .data(pm_data));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("counts: checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic cmp_flags(input string what, input logic [3:0] exp,
                           input mcuie_pkg::mcuie_flags_s got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fails++;
    end
  endtask
  function automatic logic [15:0] wr(mcuie_pkg::mcuie_op_e op, logic d, logic [2:0] b,
                                     logic [6:0] a);
    return {op, d, b, a};
  endfunction
  function automatic logic [15:0] wi(mcuie_pkg::mcuie_op_e op, logic [10:0] v);
    return {op, v};
  endfunction
  // place one word and advance the load address
  task automatic p(input logic [15:0] w);
    u_mcuie_prog_rom.mem[at] = w;
    at = at + 11'h001;
  endtask
  // hold reset, blank the program and check reset values
  task automatic restart;
    @(negedge ref_clk);
    nrst = 1'b0;
    foreach (u_mcuie_prog_rom.mem[k]) u_mcuie_prog_rom.mem[k] = 16'h0000;
    at = 11'h000;
    repeat (8) @(negedge ref_clk);
    cmp_val("reset acc", 16'h0000, {8'h00, acc});
    cmp_flags("reset flags", 4'h0, flags);
    cmp_val("reset pc", 16'h0000, {5'h00, pm_addr});
    cmp_val("reset exec", 16'h0000, {15'h0000, exec_valid});
  endtask
  // run until n more words execute, then judge timing, acc and flags
  task automatic step(input int n, input int edges, input logic [7:0] a, input logic [3:0] f);
    int seen;
    int cyc;
    seen = 0;
    cyc = 0;
    nrst = 1'b1;
    while (seen < n) begin
      @(negedge ref_clk);
      cyc++;
      if (exec_valid === 1'b1) seen++;
      if (cyc > 64) begin
        fails++;
        $display("unexpected stall: expected %0d words, seen %0d", n, seen);
        report_and_stop;
      end
    end
    cmp_val("cycles", 16'(edges), 16'(cyc));
    cmp_val("acc", {8'h00, a}, {8'h00, acc});
    cmp_flags("flags", f, flags);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_arith;
    restart;
    p(wi(mcuie_pkg::load_imm_op, 11'h03a));
    p(wi(mcuie_pkg::add_imm_op, 11'h0c9));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h20));
    p(wi(mcuie_pkg::imm_minus_acc_op, 11'h005));
    p(wr(mcuie_pkg::minus_acc_op, 1'b0, 3'h0, 7'h20));
    p(wr(mcuie_pkg::add_reg_acc_op, 1'b1, 3'h0, 7'h20));
    p(wr(mcuie_pkg::MOVE_TO_ACC_OP, 1'b0, 3'h0, 7'h20));
    p(wi(mcuie_pkg::imm_minus_acc_op, 11'h004));
    step(2, 3, 8'h03, 4'h3);
    step(2, 2, 8'h02, 4'h3);
    step(1, 1, 8'h01, 4'h3);
    step(2, 2, 8'h04, 4'h0);
    step(1, 1, 8'h00, 4'h7);
    $display("test arith done");
  endtask
  task automatic test_logic;
    restart;
    p(wi(mcuie_pkg::load_imm_op, 11'h0f0));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h21));
    p(wi(mcuie_pkg::load_imm_op, 11'h03c));
    p(wr(mcuie_pkg::and_reg_acc_op, 1'b0, 3'h0, 7'h21));
    p(wi(mcuie_pkg::and_imm_op, 11'h03f));
    p(wi(mcuie_pkg::or_imm_op, 11'h00f));
    p(wr(mcuie_pkg::xor_reg_acc_op, 1'b1, 3'h0, 7'h21));
    p(wr(mcuie_pkg::invert_op, 1'b0, 3'h0, 7'h21));
    p(wr(mcuie_pkg::nibble_exchange_op, 1'b0, 3'h0, 7'h21));
    p(wr(mcuie_pkg::plus_one_op, 1'b1, 3'h0, 7'h21));
    p(wr(mcuie_pkg::minus_one_op, 1'b0, 3'h0, 7'h21));
    p(wi(mcuie_pkg::NOP_OP, 11'h000));
    p(wi(mcuie_pkg::xor_imm_op, 11'h0cf));
    p(wr(mcuie_pkg::rotate_left_op, 1'b0, 3'h0, 7'h21));
    p(wr(mcuie_pkg::rotate_right_op, 1'b0, 3'h0, 7'h21));
    step(4, 5, 8'h30, 4'h0);
    step(2, 2, 8'h3f, 4'h0);
    step(1, 1, 8'h3f, 4'h0);
    step(1, 1, 8'h30, 4'h0);
    step(1, 1, 8'hfc, 4'h0);
    step(2, 2, 8'hcf, 4'h0);
    step(1, 1, 8'hcf, 4'h0);
    step(1, 1, 8'h00, 4'h4);
    step(1, 1, 8'ha0, 4'h5);
    step(1, 1, 8'he8, 4'h4);
    $display("test logic done");
  endtask
  task automatic test_skip;
    restart;
    p(wi(mcuie_pkg::load_imm_op, 11'h0ff));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h22));
    p(wr(mcuie_pkg::plus_one_skip_zero_op, 1'b1, 3'h0, 7'h22));
    p(wi(mcuie_pkg::load_imm_op, 11'h011));
    p(wr(mcuie_pkg::minus_one_skip_zero_op, 1'b0, 3'h0, 7'h22));
    p(wr(mcuie_pkg::bit_set_op, 1'b1, 3'h3, 7'h22));
    p(wr(mcuie_pkg::test_skip_set_op, 1'b0, 3'h3, 7'h22));
    p(wi(mcuie_pkg::load_imm_op, 11'h022));
    p(wr(mcuie_pkg::test_skip_clear_op, 1'b0, 3'h3, 7'h22));
    p(wr(mcuie_pkg::bit_clear_op, 1'b1, 3'h3, 7'h22));
    p(wr(mcuie_pkg::test_skip_clear_op, 1'b0, 3'h3, 7'h22));
    p(wi(mcuie_pkg::load_imm_op, 11'h033));
    p(wr(mcuie_pkg::MOVE_TO_ACC_OP, 1'b0, 3'h0, 7'h22));
    step(4, 6, 8'hff, 4'h0);
    step(6, 8, 8'h00, 4'h4);
    $display("test skip done");
  endtask
  task automatic test_control;
    restart;
    p(wi(mcuie_pkg::CALL_OP, 11'h010));
    p(wi(mcuie_pkg::JUMP_OP, 11'h020));
    at = 11'h010;
    p(wi(mcuie_pkg::load_imm_op, 11'h001));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h0a));
    p(wi(mcuie_pkg::load_imm_op, 11'h005));
    p(wr(mcuie_pkg::add_reg_acc_op, 1'b1, 3'h0, 7'h02));
    at = 11'h119;
    p(wi(mcuie_pkg::return_with_imm_op, 11'h05a));
    at = 11'h020;
    p(wi(mcuie_pkg::CALL_OP, 11'h030));
    p(wi(mcuie_pkg::CALL_OP, 11'h040));
    p(wi(mcuie_pkg::xor_imm_op, 11'h00f));
    at = 11'h030;
    p(wi(mcuie_pkg::load_imm_op, 11'h066));
    p(wi(mcuie_pkg::RETURN_OP, 11'h000));
    at = 11'h040;
    p(wi(mcuie_pkg::interrupt_return_op, 11'h000));
    step(6, 9, 8'h5a, 4'h0);
    cmp_val("return pc", 16'h0001, {5'h00, pm_addr});
    step(7, 13, 8'h69, 4'h0);
    cmp_val("int enable", 16'h0001, {15'h0000, int_en});
    int_ack = 1'b1;
    @(negedge ref_clk);
    int_ack = 1'b0;
    cmp_val("int enable ack", 16'h0000, {15'h0000, int_en});
    $display("test control done");
  endtask
  task automatic test_bank;
    restart;
    p(wi(mcuie_pkg::load_imm_op, 11'h05c));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h0f));
    p(wr(mcuie_pkg::bit_set_op, 1'b1, 3'h7, 7'h03));
    p(wi(mcuie_pkg::load_imm_op, 11'h0a3));
    p(wr(mcuie_pkg::MOVE_TO_REG_OP, 1'b1, 3'h0, 7'h0f));
    p(wr(mcuie_pkg::bit_clear_op, 1'b1, 3'h7, 7'h03));
    p(wr(mcuie_pkg::MOVE_TO_ACC_OP, 1'b0, 3'h0, 7'h0f));
    p(wr(mcuie_pkg::bit_set_op, 1'b1, 3'h7, 7'h03));
    p(wr(mcuie_pkg::MOVE_TO_ACC_OP, 1'b0, 3'h0, 7'h0f));
    p(wr(mcuie_pkg::CLEAR_OP, 1'b0, 3'h0, 7'h00));
    step(3, 4, 8'h5c, 4'h8);
    step(4, 4, 8'h5c, 4'h0);
    step(2, 2, 8'ha3, 4'h8);
    step(1, 1, 8'h00, 4'hc);
    $display("test bank done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    test_arith;
    test_logic;
    test_skip;
    test_control;
    test_bank;
    report_and_stop;
  end
endmodule // mcuie_core_tb_top
`default_nettype wire
